// ==== design/fcct_pkg.sv ====
package fcct_pkg;
  localparam int FCCT_NCH = 4;
  localparam int FCCT_W = 8;
  // register offsets on the wishbone bus (byte addresses)
  localparam logic [5:0] FCCT_OFF_CTRL0 = 6'h00;
  localparam logic [5:0] FCCT_OFF_TC0 = 6'h10;
  localparam logic [5:0] FCCT_OFF_CNT0 = 6'h20;
  localparam logic [5:0] FCCT_OFF_VEC = 6'h30;
  localparam logic [5:0] FCCT_OFF_IACK = 6'h34;
  localparam logic [5:0] FCCT_OFF_SNOOP = 6'h38;
  localparam logic [5:0] FCCT_OFF_STAT = 6'h3c;
  // control word fields
  localparam int FCCT_B_IE = 7;
  localparam int FCCT_B_TIMER = 6;
  localparam int FCCT_B_P256 = 5;
  localparam int FCCT_B_RISE = 4;
  localparam int FCCT_B_TRIG = 3;
  localparam int FCCT_B_TCF = 2;
  localparam int FCCT_B_RST = 1;
  localparam logic [7:0] FCCT_P16_MAX = 8'h0f;
  localparam logic [7:0] FCCT_P256_MAX = 8'hff;
  localparam logic [7:0] FCCT_RETURN_FROM_IRQ_OPCODE_B0 = 8'hed;
  localparam logic [7:0] FCCT_RETURN_FROM_IRQ_OPCODE_B1 = 8'h4d;
  localparam logic [7:0] FCCT_RST_VAL = 8'h00;

  typedef struct packed {
    logic [FCCT_NCH-1:0] zc;
    logic int_n;
    logic prio_out;
  } fcct_out_t;
endpackage

// ==== design/fcct_top.sv ====
// Summary of operation
// R1 - four channels, each with 8-bit constant, control, down-counter, prescaler
// R2 - constant loads into down-counter at start and whenever it reaches zero
// R3 - constant 1..256 supported; zero written means 256 counts
// R4 - write after a control word with constant flag is the time constant
// R5 - counter mode decrements on each selected external edge
// R6 - timer mode decrements on each prescaler tick
// R7 - down-counter readable at any time without disturbing it
// R8 - prescaler runs only in timer mode, divide by 16 or 256
// R9 - channel idle after reset until control word and constant written
// R10 - software writes vector word before enabling interrupts
// R11 - enabled channel raises active-low request at zero count
// R12 - acknowledge returns vector of requesting channel
// R13 - data bus snooped for return-from-interrupt sequence
// R14 - fixed priority, channel 0 highest then 1, 2, 3
// R15 - priority in and out high, no pending: request line high
// R16 - request drives priority out low; accepted request releases line
// R17 - priority in low forces priority out low
// R18 - no new request while priority in is low
// R19 - priority in falling suspends service in progress
// R20 - reset stops all channels and clears interrupt enables
// R21 - two-bit channel select decodes the target channel
// R22 - return sequence is bytes ed then 4d
// R23 - zero count emits one-cycle high pulse on channel output
// R24 - pending held until serviced; next pending presented after return
// R25 - interrupt disabled: reload and pulse still, no request
module fcct_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // channel pins
  input wire logic [fcct_pkg::FCCT_NCH-1:0] ext_edge_input_i,
  output logic [fcct_pkg::FCCT_NCH-1:0] zero_count_pulse_o,
  // daisy chain
  input wire logic priority_in_i,
  output logic priority_out_o,
  output logic int_n_o
);
  import fcct_pkg::*;

  typedef struct packed {
    logic [FCCT_NCH-1:0][7:0] ctrl; // R1
    logic [FCCT_NCH-1:0][7:0] tc;
    logic [FCCT_NCH-1:0][7:0] cnt;
    logic [FCCT_NCH-1:0][7:0] pre;
    logic [FCCT_NCH-1:0] run;
    logic [FCCT_NCH-1:0] tc_got;
    logic [FCCT_NCH-1:0] tc_next;
    logic [FCCT_NCH-1:0] armed;
    logic [FCCT_NCH-1:0] edge_q;
    logic [FCCT_NCH-1:0] pend;
    logic [FCCT_NCH-1:0] srv;
    logic [7:0] vec;
    logic snoop_ed;
    logic [31:0] rdat;
    logic ack;
    fcct_out_t o;
  } fcct_state_t;

  fcct_state_t st, next_st;

  logic wr, rd;
  logic [1:0] ch_sel;
  logic [FCCT_NCH-1:0] any_srv_above;
  logic [FCCT_NCH-1:0] blocked;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack;
  assign ch_sel = wb_adr_i[3:2]; // R21

  // a channel may request only if no channel above it is pending and none at or above it is in service
  always_comb begin
    blocked[0] = 1'b0;
    for (int i = 1; i < FCCT_NCH; i++) begin
      blocked[i] = blocked[i-1] | st.srv[i-1] | st.pend[i-1];
    end
    any_srv_above = blocked;
  end

  always_comb begin
    logic edge_hit;
    logic tick;
    logic zero;
    logic ie;
    logic acked;
    logic [7:0] v;
    logic hi;
    logic [FCCT_NCH-1:0] pend_set;
    edge_hit = 1'b0;
    pend_set = '0;
    tick = 1'b0;
    zero = 1'b0;
    ie = 1'b0;
    acked = 1'b0;
    v = 8'h00;
    hi = 1'b0;
    next_st = st;
    next_st.ack = 1'b0;
    next_st.o.zc = '0;
    next_st.edge_q = ext_edge_input_i;

    for (int i = 0; i < FCCT_NCH; i++) begin
      ie = st.ctrl[i][FCCT_B_IE];
      edge_hit = st.ctrl[i][FCCT_B_RISE] ?
        (ext_edge_input_i[i] & ~st.edge_q[i]) :
        (~ext_edge_input_i[i] & st.edge_q[i]);
      tick = 1'b0;
      if (st.run[i] && st.ctrl[i][FCCT_B_TIMER]) begin
        // R8
        if (!st.armed[i]) begin
          if (edge_hit) begin
            next_st.armed[i] = 1'b1;
          end
        end else if (st.pre[i] == (st.ctrl[i][FCCT_B_P256] ?
                     FCCT_P256_MAX : FCCT_P16_MAX)) begin
          next_st.pre[i] = 8'h00;
          tick = 1'b1; // R6
        end else begin
          next_st.pre[i] = st.pre[i] + 8'h01;
        end
      end else if (st.run[i]) begin
        tick = edge_hit; // R5
      end
      if (tick) begin
        zero = (st.cnt[i] == 8'h01);
        if (zero) begin
          next_st.cnt[i] = st.tc[i]; // R2 R3
          next_st.o.zc[i] = 1'b1; // R23 R25
          if (ie) begin
            pend_set[i] = 1'b1; // R11 R24
          end
        end else begin
          next_st.cnt[i] = st.cnt[i] - 8'h01;
        end
      end
    end

    // register writes
    if (wr) begin
      if (wb_adr_i[5:4] == FCCT_OFF_CTRL0[5:4]) begin
        next_st.ctrl[ch_sel] = wb_dat_i[7:0];
        next_st.tc_next[ch_sel] = wb_dat_i[FCCT_B_TCF]; // R4
        if (wb_dat_i[FCCT_B_RST]) begin
          next_st.run[ch_sel] = 1'b0;
          next_st.tc_got[ch_sel] = 1'b0;
          next_st.armed[ch_sel] = 1'b0;
        end
        if (!wb_dat_i[FCCT_B_IE]) begin
          next_st.pend[ch_sel] = 1'b0;
        end
      end else if (wb_adr_i[5:4] == FCCT_OFF_TC0[5:4]) begin
        if (st.tc_next[ch_sel]) begin
          next_st.tc[ch_sel] = wb_dat_i[7:0]; // R4
          next_st.tc_next[ch_sel] = 1'b0;
          if (!st.run[ch_sel]) begin
            next_st.cnt[ch_sel] = wb_dat_i[7:0]; // R2
            next_st.pre[ch_sel] = 8'h00;
            next_st.tc_got[ch_sel] = 1'b1;
            next_st.run[ch_sel] = 1'b1; // R9
            next_st.armed[ch_sel] = ~st.ctrl[ch_sel][FCCT_B_TRIG];
          end
        end
      end else if (wb_adr_i == FCCT_OFF_VEC) begin
        next_st.vec = {wb_dat_i[7:3], 3'b000}; // R10
      end else if (wb_adr_i == FCCT_OFF_SNOOP) begin
        // R13 R22
        if (st.snoop_ed && wb_dat_i[7:0] == FCCT_RETURN_FROM_IRQ_OPCODE_B1) begin
          hi = 1'b0;
          for (int i = 0; i < FCCT_NCH; i++) begin
            if (!hi && st.srv[i] && priority_in_i) begin
              next_st.srv[i] = 1'b0; // R24
              hi = 1'b1;
            end
          end
        end
        next_st.snoop_ed = (wb_dat_i[7:0] == FCCT_RETURN_FROM_IRQ_OPCODE_B0);
      end
    end

    // reads
    next_st.rdat = 32'h0000_0000;
    if (rd) begin
      case (wb_adr_i[5:4])
        2'b00: next_st.rdat = {24'h0, st.ctrl[ch_sel]};
        2'b01: next_st.rdat = {24'h0, st.tc[ch_sel]};
        2'b10: next_st.rdat = {24'h0, st.cnt[ch_sel]}; // R7
        default: begin
          if (wb_adr_i == FCCT_OFF_VEC) begin
            next_st.rdat = {24'h0, st.vec};
          end else if (wb_adr_i == FCCT_OFF_IACK) begin
            // R12 R14
            acked = 1'b0;
            v = st.vec;
            if (priority_in_i) begin
              for (int i = 0; i < FCCT_NCH; i++) begin
                if (!acked && st.pend[i] && !any_srv_above[i]
                    && !st.srv[i]) begin
                  acked = 1'b1;
                  v = {st.vec[7:3], 2'(i), 1'b0};
                  next_st.pend[i] = 1'b0; // R16
                  next_st.srv[i] = 1'b1;
                end
              end
            end
            next_st.rdat = {23'h0, acked, v};
          end else if (wb_adr_i == FCCT_OFF_STAT) begin
            next_st.rdat = {16'h0, st.srv, st.pend, st.run, st.tc_got};
          end
        end
      endcase
    end
    next_st.ack = (wb_cyc_i && wb_stb_i && !st.ack);
    // a zero count in the same cycle as an acknowledge keeps its request
    next_st.pend = next_st.pend | pend_set; // R24

    // daisy chain outputs; request held off while priority in low
    next_st.o.int_n = !((|(st.pend & ~any_srv_above & ~st.srv))
                        && priority_in_i && !(|st.srv)); // R11 R15 R18
    next_st.o.prio_out = priority_in_i && !(|st.srv)
                         && !(|st.pend); // R15 R16 R17 R19

    if (sys_rst_i) begin
      next_st = '0; // R20
      next_st.o.int_n = 1'b1;
      next_st.vec = FCCT_RST_VAL;
      // start from the pin level so no false edge follows reset
      next_st.edge_q = ext_edge_input_i;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign wb_dat_o = st.rdat;
  assign wb_ack_o = st.ack;
  assign zero_count_pulse_o = st.o.zc;
  assign priority_out_o = st.o.prio_out;
  assign int_n_o = st.o.int_n;

  a_prio_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !priority_in_i |=> !priority_out_o) // R17
    else $error("priority out high while priority in low");
  a_no_req_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !priority_in_i |=> int_n_o) // R18
    else $error("request raised while priority in low");
  a_req_blocks: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !int_n_o |-> !priority_out_o) // R16
    else $error("request without priority out low");
  a_zc_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    zero_count_pulse_o[0] |=> !zero_count_pulse_o[0]) // R23
    else $error("zero count pulse longer than one cycle");
  a_reload_tc: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(zero_count_pulse_o[0]) |-> st.cnt[0] == st.tc[0]) // R2
    else $error("counter not reloaded at zero");
  a_idle_reset: assert property (@(posedge clk_i)
    sys_rst_i |=> st.run == '0 && int_n_o) // R20
    else $error("channel running after reset");
  a_ack_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wb_ack_o |=> !wb_ack_o) // bus ack lasts one cycle
    else $error("ack held two cycles");
  a_idle_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !st.run[0] |=> !zero_count_pulse_o[0]) // R9
    else $error("idle channel pulsed");
endmodule

// ==== sim/fcct_chain_peer.sv ====
module fcct_chain_peer (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // upstream peer state
  input wire logic busy_i,
  output logic priority_in_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // a higher peer in service blocks everything below it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) priority_in_o <= 1'b1;
    else priority_in_o <= !busy_i;
  end
endmodule

// ==== sim/fcct_top_tb.sv ====
module fcct_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fcct_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, cyc = 0, stb = 0, we = 0, busy = 0;
  logic [5:0] adr = '0;
  logic [31:0] dat = '0, rdat;
  logic [3:0] edge_r = '0, zc;
  logic ack, pin, pout, int_n;
  logic [7:0] vec;
  logic [31:0] expq [$];
  int failures = 0, compares = 0, lowreq, b0;
  int zc_cnt [4] = '{0, 0, 0, 0};

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  fcct_chain_peer peer (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .busy_i(busy), .priority_in_o(pin));
  fcct_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_edge_input_i(edge_r), .zero_count_pulse_o(zc),
    .priority_in_i(pin), .priority_out_o(pout), .int_n_o(int_n));

  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk(input string n, input logic e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      stop_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  task automatic pulse(input int ch, input int k);
    repeat (k) begin
      edge_r[ch] <= 1'b1;
      repeat (2) @(posedge clk_i);
      edge_r[ch] <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask

  task automatic wait_req();
    int n;
    n = 0;
    while (int_n !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk("request", 1'b0, int_n);
  endtask

  // read results are matched against the oldest expectation
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) cmp("stray read", 32'h0, 32'hffffffff);
      else cmp("read data", expq.pop_front(), rdat);
    end
    if (!sys_rst_i) begin
      for (int i = 0; i < 4; i++) zc_cnt[i] += int'(zc[i]);
    end
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    stop_test();
  end

  initial begin
    void'($urandom(78));
    vec = 8'($urandom) & 8'hf8;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk("request idle", 1'b1, int_n);
    repeat (2) @(posedge clk_i);
    chk("chain out", 1'b1, pout);
    bus(1'b1, FCCT_OFF_VEC, vec | 8'h07);
    rd(FCCT_OFF_VEC, {24'h0, vec});
    bus(1'b1, FCCT_OFF_CTRL0 + 6'h04, 8'h14);
    bus(1'b1, FCCT_OFF_TC0 + 6'h04, 8'h00);
    pulse(1, 3);
    rd(FCCT_OFF_CNT0 + 6'h04, 32'h000000fd);
    rd(FCCT_OFF_CNT0 + 6'h04, 32'h000000fd);
    pulse(1, 252);
    chk("zc1 early", 1'b1, zc_cnt[1] == 0);
    pulse(1, 1);
    chk("zc1 at end", 1'b1, zc_cnt[1] == 1);
    chk("no request", 1'b1, int_n);
    $display("test counter done");
    busy <= 1'b1;
    bus(1'b1, FCCT_OFF_CTRL0, 8'hc4);
    bus(1'b1, FCCT_OFF_TC0, 8'h01);
    bus(1'b1, FCCT_OFF_CTRL0 + 6'h08, 8'he4);
    bus(1'b1, FCCT_OFF_TC0 + 6'h08, 8'h01);
    lowreq = 0;
    b0 = zc_cnt[0];
    repeat (300) begin
      @(posedge clk_i);
      if (int_n !== 1'b1) lowreq++;
    end
    chk("held off", 1'b1, lowreq == 0);
    chk("chain blocked", 1'b0, pout);
    chk("div 16", 1'b1, (zc_cnt[0] - b0) inside {18, 19});
    chk("div 256", 1'b1, zc_cnt[2] == 1);
    bus(1'b1, FCCT_OFF_CTRL0, 8'h82);
    bus(1'b1, FCCT_OFF_CTRL0 + 6'h08, 8'h82);
    busy <= 1'b0;
    wait_req();
    chk("chain out req", 1'b0, pout);
    rd(FCCT_OFF_IACK, {23'h0, 1'b1, vec});
    repeat (2) @(posedge clk_i);
    chk("released", 1'b1, int_n);
    bus(1'b1, FCCT_OFF_SNOOP, 8'hed);
    bus(1'b1, FCCT_OFF_SNOOP, 8'h4d);
    wait_req();
    rd(FCCT_OFF_IACK, {23'h0, 1'b1, vec | 8'h04});
    bus(1'b1, FCCT_OFF_SNOOP, 8'hed);
    bus(1'b1, FCCT_OFF_SNOOP, 8'h4d);
    repeat (3) @(posedge clk_i);
    chk("chain out idle", 1'b1, pout);
    $display("test chain done");
    stop_test();
  end
endmodule
